// *** logic/spp_pkg.sv ***
package spp_pkg;
   // Register offsets
   localparam logic [4:0] SPP_PORT_DATA_OFS = 5'h06;
   localparam logic [4:0] SPP_DIR_OFS = 5'h07;
   localparam logic [4:0] SPP_PULL_HIGH_OFS = 5'h08;
   localparam logic [4:0] SPP_PULL_LOW_OFS = 5'h09;
   localparam logic [4:0] SPP_PWM_B_CTRL_OFS = 5'h0A;
   localparam logic [4:0] SPP_OPEN_DRAIN_OFS = 5'h0B;
   localparam logic [4:0] SPP_WAKE_SEL_OFS = 5'h0D;
   localparam logic [4:0] SPP_IRQ_FLAG_OFS = 5'h0E;
   localparam logic [4:0] SPP_IRQ_EN_OFS = 5'h10;
   localparam logic [4:0] SPP_PWM_C_CTRL_OFS = 5'h11;
   localparam logic [4:0] SPP_FUNC_CTRL_OFS = 5'h12;
   localparam logic [4:0] SPP_READ_SRC_OFS = 5'h14;
   localparam logic [4:0] SPP_PIN_CFG_OFS = 5'h15;
   // Field positions
   localparam int SPP_PORT_CHANGE_BIT = 1;
   localparam int SPP_GLOBAL_IRQ_EN_BIT = 7;
   localparam int SPP_EXT_IRQ_SEL_BIT = 4;
   localparam int SPP_IR_EN_BIT = 0;
   localparam int SPP_PWM_OEN_BIT = 7;
   localparam int SPP_PWM_OAL_BIT = 6;
   localparam int SPP_BUZZ_EN_BIT = 7;
   localparam int SPP_T8_CS_BIT = 5;
   localparam int SPP_T8_LCK_BIT = 7;
   localparam int SPP_T10_CS_BIT = 5;
   // Configuration word bits
   localparam int SPP_CFG_RST_BIT = 0;
   localparam int SPP_CFG_CLKOUT_BIT = 1;
   localparam int SPP_CFG_PIN2_PWM_BIT = 2;
   localparam int SPP_CFG_PIN2_BUZZ_BIT = 3;
   // Reset values
   localparam logic [5:0] SPP_DIR_RST = 6'h3F;
   localparam logic [7:0] SPP_REG_RST = 8'h00;
   // Operating modes
   localparam logic [1:0] SPP_MODE_NORMAL = 2'h0;
   localparam logic [1:0] SPP_MODE_STANDBY = 2'h2;
endpackage

// *** logic/spp_sync_if.sv ***
`timescale 1ns/100ps
interface spp_sync_if;
   logic [5:0] raw;
   logic [5:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface

// *** logic/spp_sync.sv ***
`timescale 1ns/100ps
module spp_sync (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Pins in and synchronised out
   spp_sync_if.dst bus
);
   logic [5:0] meta_q;
   logic [5:0] sync_q;

   // Two stages; first stage read only by second
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= 6'h00;
         sync_q <= 6'h00;
      end else begin
         meta_q <= bus.raw;
         sync_q <= meta_q;
      end
   end

   assign bus.sync = sync_q;
endmodule

// *** logic/spp_port.sv ***
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// R1 - Six pins read and written through one port data register.
// R2 - Direction bits choose input or output per pin.
// R3 - Pull-high bits enable pull-ups per pin while input.
// R4 - Pull-low only pins 0-3, enabled by bits 7:4.
// R5 - Open-drain bits choose push-pull or open-drain per output.
// R6 - Change on selected pin sets port change flag, flag bit 1.
// R7 - Change irq needs flag, change enable and global enable.
// R8 - External irq select bit 4 makes pin 0 irq input.
// R9 - External irq disables pin 0 change detect only.
// R10 - IR carrier enable drives carrier onto pin 1.
// R11 - Config word makes pin 3 active-low external reset.
// R12 - Pin 4 outputs instruction clock in normal or standby mode.
// R13 - Pin 2 is external count clock for both timers.
// R14 - Pin 2 carries PWM A or buzzer with config word.
// R15 - PWM B control bit 7 drives PWM B on pin 0.
// R16 - PWM B bit 6 set makes output active low.
// R17 - PWM C control bit 7 drives PWM C on pin 1.
// R18 - PWM C bit 6 set makes output active low.
// R19 - Read source picks pad level or output latch.
// R20 - PWM A on pin 2 forces pin 2 to output.
// R21 - Function data overrides latch at pad; latch retained.
// R22 - Change flag stays set until software writes zero.
module spp_port
   import spp_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [4:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Pads
   input wire logic [5:0] pad_in_i,
   output logic [5:0] pad_out_o,
   output logic [5:0] pad_oe_n_o,
   output logic [5:0] pad_pull_high_o,
   output logic [5:0] pad_pull_low_o,
   // Function sources
   input wire logic ir_carrier_i,
   input wire logic pwm_a_i,
   input wire logic pwm_a_active_low_i,
   input wire logic buzzer_i,
   input wire logic pwm_b_i,
   input wire logic pwm_c_i,
   input wire logic inst_clk_i,
   input wire logic [1:0] op_mode_i,
   input wire logic [7:0] pwm_a_timer_control_i,
   input wire logic [7:0] buzzer_control_register_i,
   input wire logic [7:0] timer8_mode_i,
   input wire logic [7:0] timer10_control_i,
   // Function results
   output logic ext_irq_o,
   output logic ext_count_clock_o,
   output logic timer8_ext_sel_o,
   output logic timer10_ext_sel_o,
   output logic ext_reset_n_o,
   output logic port_change_irq_o
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [5:0] latch_q;
   logic [5:0] dir_q;
   logic [5:0] pull_high_q;
   logic [3:0] pull_low_q;
   logic [5:0] open_drain_q;
   logic [5:0] wake_sel_q;
   logic change_flag_q;
   logic change_ie_q;
   logic global_irq_en_q;
   logic ext_irq_sel_q;
   logic [1:0] pwm_b_ctrl_q;
   logic [1:0] pwm_c_ctrl_q;
   logic ir_en_q;
   logic [5:0] read_src_q;
   logic [3:0] pin_cfg_q;
   logic [5:0] prev_q;
   logic [7:0] rdata_q;

   logic [5:0] pin_s;
   logic [5:0] wake_mask;
   logic change_evt;
   logic [5:0] sf_en;
   logic [5:0] sf_dt;
   logic [5:0] is_out;
   logic [5:0] drive_val;
   logic [5:0] read_val;
   logic pwm_a_on;
   logic buzz_on;
   logic clk_out_on;

   function automatic logic wr_at(input logic [4:0] ofs);
      wr_at = reg_wr_i && (reg_addr_i == ofs);
   endfunction

   // ----------------------------------------
   // Pad input synchroniser
   // ----------------------------------------
   spp_sync_if sync_bus ();
   assign sync_bus.raw = pad_in_i;
   assign pin_s = sync_bus.sync;

   spp_sync u_sync (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .bus(sync_bus)
   );

   // ----------------------------------------
   // Port data and pad configuration
   // ----------------------------------------
   // R1 - latch write
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latch_q <= 6'h00;
      end else if (wr_at(SPP_PORT_DATA_OFS)) begin
         latch_q <= reg_wdata_i[5:0];
      end
   end

   // R2 R3 R4 R5 - pad config registers
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir_q <= SPP_DIR_RST;
         pull_high_q <= 6'h00;
         pull_low_q <= 4'h0;
         open_drain_q <= 6'h00;
         read_src_q <= 6'h00;
      end else begin
         if (wr_at(SPP_DIR_OFS)) begin
            dir_q <= reg_wdata_i[5:0];
         end
         if (wr_at(SPP_PULL_HIGH_OFS)) begin
            pull_high_q <= reg_wdata_i[5:0];
         end
         if (wr_at(SPP_PULL_LOW_OFS)) begin
            pull_low_q <= reg_wdata_i[7:4];
         end
         if (wr_at(SPP_OPEN_DRAIN_OFS)) begin
            open_drain_q <= reg_wdata_i[5:0];
         end
         if (wr_at(SPP_READ_SRC_OFS)) begin
            read_src_q <= reg_wdata_i[5:0];
         end
      end
   end

   // ----------------------------------------
   // Function and interrupt controls
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_sel_q <= 6'h00;
         change_ie_q <= 1'b0;
         global_irq_en_q <= 1'b0;
         ext_irq_sel_q <= 1'b0;
         ir_en_q <= 1'b0;
         pwm_b_ctrl_q <= 2'h0;
         pwm_c_ctrl_q <= 2'h0;
         pin_cfg_q <= 4'h0;
      end else begin
         if (wr_at(SPP_WAKE_SEL_OFS)) begin
            wake_sel_q <= reg_wdata_i[5:0];
         end
         if (wr_at(SPP_IRQ_EN_OFS)) begin
            change_ie_q <= reg_wdata_i[SPP_PORT_CHANGE_BIT];
            global_irq_en_q <= reg_wdata_i[SPP_GLOBAL_IRQ_EN_BIT];
         end
         if (wr_at(SPP_FUNC_CTRL_OFS)) begin
            ext_irq_sel_q <= reg_wdata_i[SPP_EXT_IRQ_SEL_BIT];
            ir_en_q <= reg_wdata_i[SPP_IR_EN_BIT];
         end
         if (wr_at(SPP_PWM_B_CTRL_OFS)) begin
            pwm_b_ctrl_q <= {reg_wdata_i[SPP_PWM_OEN_BIT], reg_wdata_i[SPP_PWM_OAL_BIT]};
         end
         if (wr_at(SPP_PWM_C_CTRL_OFS)) begin
            pwm_c_ctrl_q <= {reg_wdata_i[SPP_PWM_OEN_BIT], reg_wdata_i[SPP_PWM_OAL_BIT]};
         end
         if (wr_at(SPP_PIN_CFG_OFS)) begin
            pin_cfg_q <= reg_wdata_i[3:0];
         end
      end
   end

   // ----------------------------------------
   // Level change detection
   // ----------------------------------------
   // R9 - ext irq masks pin 0 only
   assign wake_mask = wake_sel_q & {5'h1F, ~ext_irq_sel_q};
   // R6 - any change on selected pin
   assign change_evt = |((pin_s ^ prev_q) & wake_mask);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= 6'h00;
      end else begin
         prev_q <= pin_s;
      end
   end

   // R22 - sticky, set wins over clear
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         change_flag_q <= 1'b0;
      end else if (change_evt) begin
         change_flag_q <= 1'b1;
      end else if (wr_at(SPP_IRQ_FLAG_OFS) && !reg_wdata_i[SPP_PORT_CHANGE_BIT]) begin
         change_flag_q <= 1'b0;
      end
   end

   // R7 - three-way gate
   assign port_change_irq_o = change_flag_q & change_ie_q & global_irq_en_q;

   // ----------------------------------------
   // Special function muxing
   // ----------------------------------------
   assign pwm_a_on = pwm_a_timer_control_i[SPP_PWM_OEN_BIT] & pin_cfg_q[SPP_CFG_PIN2_PWM_BIT];
   assign buzz_on = buzzer_control_register_i[SPP_BUZZ_EN_BIT] & pin_cfg_q[SPP_CFG_PIN2_BUZZ_BIT];
   // R12 - clock out only normal or standby
   assign clk_out_on = pin_cfg_q[SPP_CFG_CLKOUT_BIT]
                       & ((op_mode_i == SPP_MODE_NORMAL) | (op_mode_i == SPP_MODE_STANDBY));

   always_comb begin
      sf_en = 6'h00;
      sf_dt = 6'h00;
      // R15 R16 - PWM B on pin 0
      sf_en[0] = pwm_b_ctrl_q[1];
      sf_dt[0] = pwm_b_i ^ pwm_b_ctrl_q[0];
      // R10 R17 R18 - IR carrier first, then PWM C on pin 1
      sf_en[1] = ir_en_q | pwm_c_ctrl_q[1];
      sf_dt[1] = ir_en_q ? ir_carrier_i : (pwm_c_i ^ pwm_c_ctrl_q[0]);
      // R14 - PWM A or buzzer on pin 2
      sf_en[2] = pwm_a_on | buzz_on;
      sf_dt[2] = pwm_a_on ? (pwm_a_i ^ pwm_a_active_low_i) : buzzer_i;
      sf_en[4] = clk_out_on;
      sf_dt[4] = inst_clk_i;
   end

   // R20 - function on pin forces output
   assign is_out = ~dir_q | sf_en;
   // R21 - function data replaces latch at pad
   assign drive_val = (sf_en & sf_dt) | (~sf_en & latch_q);

   // ----------------------------------------
   // Pad drivers
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pad_out_o <= 6'h00;
         pad_oe_n_o <= 6'h3F;
         pad_pull_high_o <= 6'h00;
         pad_pull_low_o <= 6'h00;
      end else begin
         pad_out_o <= drive_val;
         // R5 - open drain drives only low
         pad_oe_n_o <= ~(is_out & ~(open_drain_q & drive_val));
         // R3 - pull-high only while input
         pad_pull_high_o <= pull_high_q & ~is_out;
         // R4 - no pull-low on pins 4 and 5
         pad_pull_low_o <= {2'b00, pull_low_q & ~is_out[3:0]};
      end
   end

   // ----------------------------------------
   // Pin function inputs
   // ----------------------------------------
   // R8 - pin 0 external irq
   assign ext_irq_o = ext_irq_sel_q & pin_s[0];
   // R13 - pin 2 count clock selects
   assign ext_count_clock_o = pin_s[2];
   assign timer8_ext_sel_o = timer8_mode_i[SPP_T8_CS_BIT] & ~timer8_mode_i[SPP_T8_LCK_BIT];
   assign timer10_ext_sel_o = timer10_control_i[SPP_T10_CS_BIT];
   // R11 - pin 3 active-low reset
   assign ext_reset_n_o = ~(pin_cfg_q[SPP_CFG_RST_BIT] & ~pin_s[3]);

   // ----------------------------------------
   // Read back
   // ----------------------------------------
   // R19 - pad or latch per pin
   assign read_val = (read_src_q & latch_q) | (~read_src_q & pin_s);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= SPP_REG_RST;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            SPP_PORT_DATA_OFS: rdata_q <= {2'b00, read_val};
            SPP_DIR_OFS: rdata_q <= {2'b00, dir_q};
            SPP_PULL_HIGH_OFS: rdata_q <= {2'b00, pull_high_q};
            SPP_PULL_LOW_OFS: rdata_q <= {pull_low_q, 4'h0};
            SPP_OPEN_DRAIN_OFS: rdata_q <= {2'b00, open_drain_q};
            SPP_WAKE_SEL_OFS: rdata_q <= {2'b00, wake_sel_q};
            SPP_IRQ_FLAG_OFS: rdata_q <= {6'h00, change_flag_q, 1'b0};
            SPP_IRQ_EN_OFS: rdata_q <= {global_irq_en_q, 5'h00, change_ie_q, 1'b0};
            SPP_FUNC_CTRL_OFS: rdata_q <= {3'h0, ext_irq_sel_q, 3'h0, ir_en_q};
            SPP_READ_SRC_OFS: rdata_q <= {2'b00, read_src_q};
            SPP_PIN_CFG_OFS: rdata_q <= {4'h0, pin_cfg_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   flag_sticky_a: assert property (change_flag_q && !(wr_at(SPP_IRQ_FLAG_OFS) // R22
      && !reg_wdata_i[SPP_PORT_CHANGE_BIT]) |=> change_flag_q) else $error("change flag dropped");
   flag_set_a: assert property (change_evt |=> change_flag_q) else $error("change not flagged"); // R6
   irq_gate_a: assert property (port_change_irq_o == (change_flag_q && change_ie_q && global_irq_en_q)) // R7
      else $error("irq gate wrong");
   pin0_mask_a: assert property (ext_irq_sel_q |-> !wake_mask[0]) else $error("pin0 not masked"); // R9
   pull_low_a: assert property (pad_pull_low_o[5:4] == 2'b00) else $error("pull low on pin4/5"); // R4
   pwm_b_pol_a: assert property (pwm_b_ctrl_q == 2'b11 |=> pad_out_o[0] == !$past(pwm_b_i)) // R16
      else $error("pwm b polarity");
   pwm_a_out_a: assert property (pwm_a_on |=> !pad_oe_n_o[2] || $past(open_drain_q[2])) // R20
      else $error("pin2 not output");
   latch_keep_a: assert property (sf_en[1] && !wr_at(SPP_PORT_DATA_OFS) |=> $stable(latch_q)) // R21
      else $error("latch lost");
   ext_irq_a: assert property (!ext_irq_sel_q |-> !ext_irq_o) else $error("ext irq without select"); // R8
   rst_pin_a: assert property (!pin_cfg_q[0] |-> ext_reset_n_o) else $error("reset pin unselected"); // R11

   flag_cov_c: cover property (change_evt ##1 change_flag_q);
   irq_cov_c: cover property (port_change_irq_o);
   pwm_c_cov_c: cover property (pwm_c_ctrl_q[1] && !ir_en_q);
   read_cov_c: cover property (reg_rd_i && reg_addr_i == SPP_PORT_DATA_OFS);
endmodule

// *** tb/spp_pad_model.sv ***
`timescale 1ns/100ps
module spp_pad_model (
   // Clock
   input wire logic mclk_i,
   // Device side of the pads
   input wire logic [5:0] pad_out_i,
   input wire logic [5:0] pad_oe_n_i,
   input wire logic [5:0] pull_high_i,
   input wire logic [5:0] pull_low_i,
   // Outside drivers
   input wire logic [5:0] ext_val_i,
   input wire logic [5:0] ext_en_i,
   // Resolved pad level
   output logic [5:0] level_o
);
   // Undriven pins toggle so a stale value is never mistaken for a level
   logic [5:0] float_q = 6'h00;
   always_ff @(posedge mclk_i) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!pad_oe_n_i[i]) begin
            level_o[i] = pad_out_i[i];
         end else if (ext_en_i[i]) begin
            level_o[i] = ext_val_i[i];
         end else if (pull_high_i[i]) begin
            level_o[i] = 1'b1;
         end else if (pull_low_i[i]) begin
            level_o[i] = 1'b0;
         end else begin
            level_o[i] = float_q[i];
         end
      end
   end
endmodule

// *** tb/spp_port_test.sv ***
`timescale 1ns/100ps
module spp_port_test;
   import spp_pkg::*;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [5:0] pad_in_i, pad_out_o, pad_oe_n_o, ph, pl;
   logic [5:0] ext_val = 6'h15;
   logic [5:0] ext_en = 6'h3F;
   logic ir_i = 1'b0, pa_i = 1'b0, pa_al = 1'b0, bz_i = 1'b0, pb_i = 1'b0, pc_i = 1'b0, ck_i = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [7:0] pa_ctl = 8'h00, bz_ctl = 8'h00, t8 = 8'h00, t10 = 8'h00;
   logic ext_irq_o, cnt_o, t8_o, t10_o, rst_n_o, irq_o;
   int err_total = 0;
   int n_tests = 0;
   spp_port u_spp_port (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pad_pull_high_o(ph),
      .pad_pull_low_o(pl), .ir_carrier_i(ir_i), .pwm_a_i(pa_i), .pwm_a_active_low_i(pa_al),
      .buzzer_i(bz_i), .pwm_b_i(pb_i), .pwm_c_i(pc_i), .inst_clk_i(ck_i), .op_mode_i(mode),
      .pwm_a_timer_control_i(pa_ctl), .buzzer_control_register_i(bz_ctl), .timer8_mode_i(t8),
      .timer10_control_i(t10), .ext_irq_o(ext_irq_o), .ext_count_clock_o(cnt_o),
      .timer8_ext_sel_o(t8_o), .timer10_ext_sel_o(t10_o), .ext_reset_n_o(rst_n_o),
      .port_change_irq_o(irq_o));
   spp_pad_model u_spp_pad_model (.mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
      .pull_high_i(ph), .pull_low_i(pl), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pad_in_i));
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   // ----------------
   // Access tasks
   // ----------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk("rdata", reg_rdata_o, e);
   endtask
   // Covers two sync flops plus the registered pad stage
   task automatic settle();
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
   task automatic wo(input logic [4:0] a, input logic [7:0] d, input logic [5:0] e);
      wr(a, d);
      settle();
      chk("pad_out", {2'h0, pad_out_o}, {2'h0, e});
   endtask
   task automatic conclude();
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   // ----------------
   // Tests
   // ----------------
   initial begin
      repeat (16) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      rd(SPP_DIR_OFS, 8'h3F);
      chk("oe_n", {2'h0, pad_oe_n_o}, 8'h3F);
      rd(5'h1F, 8'h00);
      rd(SPP_PWM_B_CTRL_OFS, 8'h00);
      rd(SPP_PORT_DATA_OFS, 8'h15);
      wr(SPP_PULL_HIGH_OFS, 8'h3F);
      ext_en <= 6'h00;
      settle();
      chk("pull_high", {2'h0, ph}, 8'h3F);
      rd(SPP_PORT_DATA_OFS, 8'h3F);
      wr(SPP_PULL_LOW_OFS, 8'hFF);
      settle();
      chk("pull_low", {2'h0, pl}, 8'h0F);
      wr(SPP_PULL_HIGH_OFS, 8'h00);
      wr(SPP_PULL_LOW_OFS, 8'h00);
      ext_en <= 6'h3F;
      wr(SPP_WAKE_SEL_OFS, 8'h08);
      settle();
      rd(SPP_IRQ_FLAG_OFS, 8'h00);
      ext_val <= 6'h1D;
      settle();
      rd(SPP_IRQ_FLAG_OFS, 8'h02);
      wr(SPP_IRQ_FLAG_OFS, 8'h02);
      rd(SPP_IRQ_FLAG_OFS, 8'h02);
      wr(SPP_IRQ_EN_OFS, 8'h02);
      settle();
      chk("irq", {7'h00, irq_o}, 8'h00);
      wr(SPP_IRQ_EN_OFS, 8'h82);
      settle();
      chk("irq", {7'h00, irq_o}, 8'h01);
      wr(SPP_IRQ_FLAG_OFS, 8'h00);
      rd(SPP_IRQ_FLAG_OFS, 8'h00);
      chk("irq", {7'h00, irq_o}, 8'h00);
      wr(SPP_FUNC_CTRL_OFS, 8'h10);
      wr(SPP_WAKE_SEL_OFS, 8'h03);
      ext_val <= 6'h1C;
      settle();
      chk("ext_irq", {7'h00, ext_irq_o}, 8'h00);
      rd(SPP_IRQ_FLAG_OFS, 8'h00);
      ext_val <= 6'h1F;
      settle();
      chk("ext_irq", {7'h00, ext_irq_o}, 8'h01);
      rd(SPP_IRQ_FLAG_OFS, 8'h02);
      wr(SPP_IRQ_FLAG_OFS, 8'h00);
      wr(SPP_WAKE_SEL_OFS, 8'h00);
      wr(SPP_FUNC_CTRL_OFS, 8'h00);
      ext_val <= 6'h15;
      wr(SPP_PORT_DATA_OFS, 8'h2A);
      wo(SPP_DIR_OFS, 8'h00, 6'h2A);
      chk("oe_n", {2'h0, pad_oe_n_o}, 8'h00);
      wr(SPP_DIR_OFS, 8'h3F);
      wr(SPP_READ_SRC_OFS, 8'h3F);
      rd(SPP_PORT_DATA_OFS, 8'h2A);
      wr(SPP_READ_SRC_OFS, 8'h00);
      settle();
      rd(SPP_PORT_DATA_OFS, 8'h15);
      wr(SPP_DIR_OFS, 8'h00);
      wr(SPP_OPEN_DRAIN_OFS, 8'h3F);
      settle();
      chk("oe_n", {2'h0, pad_oe_n_o}, 8'h2A);
      wr(SPP_OPEN_DRAIN_OFS, 8'h00);
      pb_i <= 1'b1;
      wo(SPP_PWM_B_CTRL_OFS, 8'h80, 6'h2B);
      wo(SPP_PWM_B_CTRL_OFS, 8'hC0, 6'h2A);
      wo(SPP_PWM_B_CTRL_OFS, 8'h00, 6'h2A);
      wo(SPP_PWM_C_CTRL_OFS, 8'h80, 6'h28);
      wo(SPP_PWM_C_CTRL_OFS, 8'hC0, 6'h2A);
      wo(SPP_FUNC_CTRL_OFS, 8'h01, 6'h28);
      wo(SPP_FUNC_CTRL_OFS, 8'h00, 6'h2A);
      ck_i <= 1'b1;
      wo(SPP_PIN_CFG_OFS, 8'h02, 6'h3A);
      mode <= 2'h1;
      wo(SPP_PIN_CFG_OFS, 8'h02, 6'h2A);
      mode <= SPP_MODE_STANDBY;
      wo(SPP_PIN_CFG_OFS, 8'h02, 6'h3A);
      pa_i <= 1'b1;
      pa_ctl <= 8'h80;
      wr(SPP_DIR_OFS, 8'h3F);
      wo(SPP_PIN_CFG_OFS, 8'h04, 6'h2E);
      chk("oe_n", {2'h0, pad_oe_n_o}, 8'h39);
      pa_al <= 1'b1;
      settle();
      chk("pad_out", {2'h0, pad_out_o}, 8'h2A);
      pa_ctl <= 8'h00;
      bz_ctl <= 8'h80;
      bz_i <= 1'b1;
      wo(SPP_PIN_CFG_OFS, 8'h08, 6'h2E);
      wo(SPP_PIN_CFG_OFS, 8'h01, 6'h2A);
      chk("rst_n", {7'h00, rst_n_o}, 8'h00);
      ext_val <= 6'h1D;
      t8 <= 8'h20;
      t10 <= 8'h20;
      settle();
      chk("rst_n", {7'h00, rst_n_o}, 8'h01);
      chk("count", {6'h00, cnt_o, t8_o}, 8'h03);
      chk("t10_sel", {7'h00, t10_o}, 8'h01);
      t8 <= 8'hA0;
      settle();
      chk("t8_sel", {7'h00, t8_o}, 8'h00);
      conclude();
   end
endmodule
